// File: hdl/trap_bus_error_handling.sv
`timescale 1ns/100ps
module trap_bus_error_handling (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire trap_pkg::trap_cond_t cond,
    input wire logic [15:0] trap_instr_vec,
    input wire logic int_req,
    input wire logic [2:0] int_prio,
    input wire logic [15:0] int_vec,
    input wire logic [15:0] pc_in,
    input wire logic [15:0] status_in,
    input wire logic [15:0] ksp_in,
    input wire trap_pkg::fault_ctx_t fault,
    input wire logic [15:0] ir,
    input wire trap_pkg::mem_rsp_t mem_rsp,
    output trap_pkg::mem_req_t mem_req,
    output logic busy,
    output logic halt,
    output logic handler_go,
    output logic [15:0] pc_out,
    output logic [15:0] status_out,
    output logic [15:0] ksp_out,
    output logic inc_keep,
    output logic inc_valid,
    output trap_pkg::op_class_t op_class
);
    // ==========================================================
    // Decode helpers
    // Extended-set decoder, shared by the registered class and fault logic
    function automatic trap_pkg::op_class_t decode_op(input logic [15:0] w);
        trap_pkg::op_class_t c;
        c = trap_pkg::OP_BASIC;
        if (w[15:12] == trap_pkg::PAT_MOVE) c = trap_pkg::OP_MOVE;
        else if (w == trap_pkg::PAT_RETURN_TRAP) c = trap_pkg::OP_RETURN_TRAP;
        else if (w[15:9] == trap_pkg::PAT_MULTIPLY) c = trap_pkg::OP_MULTIPLY;
        else if (w[15:9] == trap_pkg::PAT_DIV) c = trap_pkg::OP_DIV;
        else if (w[15:9] == trap_pkg::PAT_ARITH_SHIFT) c = trap_pkg::OP_ARITH_SHIFT;
        else if (w[15:9] == trap_pkg::PAT_COMBINED_SHIFT) c = trap_pkg::OP_COMBINED_SHIFT;
        else if (w[15:9] == trap_pkg::PAT_XOR) c = trap_pkg::OP_XOR;
        else if (w[15:9] == trap_pkg::PAT_SUB_ONE_BRANCH) c = trap_pkg::OP_SUB_ONE_BRANCH;
        else if (w[15:6] == trap_pkg::PAT_MARK) c = trap_pkg::OP_MARK;
        else if (w[15:6] == trap_pkg::PAT_FROM_PREV) c = trap_pkg::OP_FROM_PREV;
        else if (w[15:6] == trap_pkg::PAT_TO_PREV) c = trap_pkg::OP_TO_PREV;
        else if (w[15:6] == trap_pkg::PAT_SIGN_EXTEND) c = trap_pkg::OP_SIGN_EXTEND;
        else if (w[15:6] == trap_pkg::PAT_TO_STATUS) c = trap_pkg::OP_TO_STATUS;
        else if (w[15:6] == trap_pkg::PAT_FROM_STATUS) c = trap_pkg::OP_FROM_STATUS;
        return c;
    endfunction

    // ==========================================================
    // Priority selection
    typedef enum logic [3:0] {
        S_IDLE, S_PUSH_STATUS, S_PUSH_PC, S_FIX_STATUS, S_LOAD_PC, S_LOAD_STATUS, S_CHECK
    } state_t;

    state_t state_r; // Trap sequencer state
    logic [15:0] vec_r; // Vector of the trap in progress
    logic [15:0] save_status_r; // Status word to push
    logic [15:0] save_pc_r; // Program counter to push
    logic [15:0] sp_r; // Working kernel stack pointer
    logic take_trap; // A vectored condition is pending
    logic [15:0] sel_vec; // Its vector
    logic int_wins; // Interrupt above current priority
    logic [2:0] cur_prio; // Priority field of the outgoing status

    // Idle compares with the live status, so a just-raised priority is not missed
    assign cur_prio = (state_r == S_IDLE) ? status_in[trap_pkg::PRIO_SHIFT +: 3]
                                          : status_out[trap_pkg::PRIO_SHIFT +: 3];
    assign int_wins = int_req && (int_prio > cur_prio);

    // Fixed order; halts are handled outside the vectored path
    always_comb begin
        take_trap = 1'b1;
        sel_vec = trap_pkg::VEC_BUS_ERR;
        if (cond.odd_addr) sel_vec = trap_pkg::VEC_BUS_ERR;
        else if (cond.mem_mgt) sel_vec = trap_pkg::VEC_MEM_MGT;
        else if (cond.time_out) sel_vec = trap_pkg::VEC_BUS_ERR;
        else if (cond.parity) sel_vec = trap_pkg::VEC_PARITY;
        else if (cond.trap_instr) sel_vec = trap_instr_vec;
        else if (cond.trace) sel_vec = trap_pkg::VEC_TRACE;
        else if (cond.yellow) sel_vec = trap_pkg::VEC_BUS_ERR;
        else if (cond.power_fail) sel_vec = trap_pkg::VEC_POWER;
        else if (int_wins && !cond.console_halt) sel_vec = int_vec;
        else take_trap = 1'b0;
    end

    // ==========================================================
    // Trap sequencer
    // Status, then pc pushed; vector words then fetched
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
            vec_r <= 16'h0000;
            save_status_r <= trap_pkg::STATUS_RST;
            save_pc_r <= 16'h0000;
            sp_r <= trap_pkg::SP_RST;
            mem_req <= '0;
            busy <= 1'b0;
            halt <= 1'b0;
            handler_go <= 1'b0;
            pc_out <= 16'h0000;
            status_out <= trap_pkg::STATUS_RST;
            ksp_out <= trap_pkg::SP_RST;
        end else begin
            handler_go <= 1'b0;
            unique case (state_r)
                S_IDLE: begin
                    status_out <= status_in;
                    if (cond.halt_instr) begin
                        halt <= 1'b1;
                    end else if (take_trap) begin
                        // Pc already left unincremented by the fetch fault
                        vec_r <= sel_vec;
                        save_status_r <= status_in;
                        save_pc_r <= pc_in;
                        sp_r <= ksp_in - trap_pkg::WORD_STEP;
                        mem_req <= '{rd: 1'b0, wr: 1'b1, addr: ksp_in - trap_pkg::WORD_STEP,
                                     wdata: status_in};
                        busy <= 1'b1;
                        state_r <= S_PUSH_STATUS;
                    end else if (cond.console_halt) begin
                        halt <= 1'b1;
                    end
                end
                S_PUSH_STATUS: if (mem_rsp.ack) begin
                    sp_r <= sp_r - trap_pkg::WORD_STEP;
                    mem_req <= '{rd: 1'b0, wr: 1'b1, addr: sp_r - trap_pkg::WORD_STEP,
                                 wdata: save_pc_r};
                    state_r <= S_PUSH_PC;
                end
                S_PUSH_PC: if (mem_rsp.ack) begin
                    if (mem_rsp.mm_abort) begin
                        // Abort between pushes: fetch old vector+2 as the new saved status
                        mem_req <= '{rd: 1'b1, wr: 1'b0, addr: vec_r + trap_pkg::WORD_STEP,
                                     wdata: 16'h0000};
                        state_r <= S_FIX_STATUS;
                    end else begin
                        mem_req <= '{rd: 1'b1, wr: 1'b0, addr: vec_r, wdata: 16'h0000};
                        state_r <= S_LOAD_PC;
                    end
                end
                S_FIX_STATUS: if (mem_rsp.ack) begin
                    // Restart as a memory-management trap; status goes back in its own slot
                    vec_r <= trap_pkg::VEC_MEM_MGT;
                    save_status_r <= mem_rsp.rdata;
                    sp_r <= sp_r + trap_pkg::WORD_STEP;
                    mem_req <= '{rd: 1'b0, wr: 1'b1, addr: sp_r + trap_pkg::WORD_STEP,
                                 wdata: mem_rsp.rdata};
                    state_r <= S_PUSH_STATUS;
                end
                S_LOAD_PC: if (mem_rsp.ack) begin
                    pc_out <= mem_rsp.rdata;
                    mem_req <= '{rd: 1'b1, wr: 1'b0, addr: vec_r + trap_pkg::WORD_STEP,
                                 wdata: 16'h0000};
                    state_r <= S_LOAD_STATUS;
                end
                S_LOAD_STATUS: if (mem_rsp.ack) begin
                    status_out <= mem_rsp.rdata;
                    ksp_out <= sp_r;
                    mem_req <= '0;
                    state_r <= S_CHECK;
                end
                S_CHECK: begin
                    // New handler priority known; a higher request preempts it
                    if (int_wins) begin
                        vec_r <= int_vec;
                        save_status_r <= status_out;
                        save_pc_r <= pc_out;
                        sp_r <= sp_r - trap_pkg::WORD_STEP;
                        mem_req <= '{rd: 1'b0, wr: 1'b1, addr: sp_r - trap_pkg::WORD_STEP,
                                     wdata: status_out};
                        state_r <= S_PUSH_STATUS;
                    end else begin
                        handler_go <= 1'b1;
                        busy <= 1'b0;
                        state_r <= S_IDLE;
                    end
                end
                // Unused state codes fall back to idle
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Register increment decision on bus errors
    // Fetch faults never keep the step; mode-2 keeps it only for the exceptions
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            inc_keep <= 1'b0;
            inc_valid <= 1'b0;
            op_class <= trap_pkg::OP_BASIC;
        end else begin
            op_class <= decode_op(ir);
            inc_valid <= fault.valid;
            if (!fault.valid || fault.fetch) begin
                inc_keep <= 1'b0;
            end else if (fault.mode2 && fault.odd) begin
                inc_keep <= (decode_op(ir) == trap_pkg::OP_MOVE) ||
                            (decode_op(ir) == trap_pkg::OP_TO_PREV);
            end else if (fault.mode2) begin
                inc_keep <= (decode_op(ir) == trap_pkg::OP_MOVE && fault.dest) ||
                            (decode_op(ir) == trap_pkg::OP_TO_PREV);
            end else begin
                inc_keep <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Checks
    chk_fetch_no_inc: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fault.valid && fault.fetch |=> inc_valid && !inc_keep)
        else $error("fetch fault kept increment");
    chk_nxm_fetch: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fault.valid && fault.fetch && !fault.odd |=> !inc_keep)
        else $error("nxm fetch kept increment");
    chk_odd_mode2: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fault.valid && !fault.fetch && fault.mode2 && fault.odd
        && decode_op(ir) == trap_pkg::OP_BASIC |=> !inc_keep)
        else $error("odd mode2 incremented");
    chk_nxm_to_prev: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fault.valid && !fault.fetch && fault.mode2 && !fault.odd
        && decode_op(ir) == trap_pkg::OP_TO_PREV |=> inc_keep)
        else $error("to-prev time-out not incremented");
    chk_preempt_handler: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_r == S_CHECK && int_wins |=> !handler_go && state_r == S_PUSH_STATUS)
        else $error("handler ran before higher interrupt");
    chk_odd_over_mm: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_r == S_IDLE && !cond.halt_instr && cond.odd_addr
        |=> vec_r == trap_pkg::VEC_BUS_ERR && state_r == S_PUSH_STATUS)
        else $error("odd address lost priority");
    chk_abort_fix: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_r == S_PUSH_PC && mem_rsp.ack && mem_rsp.mm_abort
        |=> mem_req.rd && mem_req.addr == $past(vec_r) + trap_pkg::WORD_STEP)
        else $error("abort did not fetch vector plus two");
    chk_push_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_r == S_PUSH_STATUS && mem_rsp.ack && mem_req.wr
        |=> mem_req.wr && mem_req.wdata == save_pc_r
        && mem_req.addr == $past(mem_req.addr) - trap_pkg::WORD_STEP)
        else $error("pc push out of order");
    chk_decode_multiply: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ir[15:9] == trap_pkg::PAT_MULTIPLY |=> op_class == trap_pkg::OP_MULTIPLY)
        else $error("multiply not decoded");
endmodule // trap_bus_error_handling

// File: hdl/trap_pkg.sv
package trap_pkg;
    // ==========================================================
    // Trap vectors (byte addresses)
    localparam logic [15:0] VEC_BUS_ERR = 16'h0004; // Odd address, time-out, yellow zone
    localparam logic [15:0] VEC_MEM_MGT = 16'h00a8; // Memory-management abort
    localparam logic [15:0] VEC_PARITY = 16'h004c; // Memory parity error
    localparam logic [15:0] VEC_TRACE = 16'h000c; // Trace trap
    localparam logic [15:0] VEC_POWER = 16'h0018; // Power fail
    localparam logic [15:0] WORD_STEP = 16'h0002; // One word in bytes
    localparam logic [2:0] PRIO_SHIFT = 3'h5; // Priority field position in status
    localparam logic [15:0] STATUS_RST = 16'h0000; // Status after reset
    localparam logic [15:0] SP_RST = 16'h0000; // Kernel stack after reset

    // ==========================================================
    // Opcode patterns for the decoder
    localparam logic [3:0] PAT_MOVE = 4'h1; // ir[15:12]
    localparam logic [6:0] PAT_MULTIPLY = 7'h38; // ir[15:9]
    localparam logic [6:0] PAT_DIV = 7'h39;
    localparam logic [6:0] PAT_ARITH_SHIFT = 7'h3a;
    localparam logic [6:0] PAT_COMBINED_SHIFT = 7'h3b;
    localparam logic [6:0] PAT_XOR = 7'h3c;
    localparam logic [6:0] PAT_SUB_ONE_BRANCH = 7'h3f;
    localparam logic [9:0] PAT_MARK = 10'h034; // ir[15:6]
    localparam logic [9:0] PAT_FROM_PREV = 10'h035;
    localparam logic [9:0] PAT_TO_PREV = 10'h036;
    localparam logic [9:0] PAT_SIGN_EXTEND = 10'h037;
    localparam logic [9:0] PAT_TO_STATUS = 10'h234;
    localparam logic [9:0] PAT_FROM_STATUS = 10'h237;
    localparam logic [15:0] PAT_RETURN_TRAP = 16'h0006;

    // Decoded instruction classes
    typedef enum logic [3:0] {
        OP_BASIC, OP_MOVE, OP_MARK, OP_RETURN_TRAP, OP_SUB_ONE_BRANCH, OP_SIGN_EXTEND,
        OP_XOR, OP_MULTIPLY, OP_DIV, OP_ARITH_SHIFT, OP_COMBINED_SHIFT, OP_TO_PREV,
        OP_FROM_PREV, OP_TO_STATUS, OP_FROM_STATUS
    } op_class_t;

    // Simultaneous trap conditions, one bit each
    typedef struct packed {
        logic halt_instr;
        logic odd_addr;
        logic mem_mgt;
        logic time_out;
        logic parity;
        logic trap_instr;
        logic trace;
        logic yellow;
        logic power_fail;
        logic console_halt;
    } trap_cond_t;

    // Bus-error context for the register increment decision
    typedef struct packed {
        logic valid;   // A bus error is being reported
        logic fetch;   // Fault was an instruction fetch through the program counter
        logic mode2;   // Operand used autoincrement mode
        logic dest;    // Operand was the destination
        logic odd;     // Odd address (otherwise non-existent memory)
    } fault_ctx_t;

    // Memory request toward the system bus
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mem_req_t;

    // Memory answer
    typedef struct packed {
        logic ack;
        logic mm_abort;
        logic [15:0] rdata;
    } mem_rsp_t;
endpackage

// File: verif/sys_mem_model.sv
`timescale 1ns/100ps
// ==========================================================
// System memory behind the trap sequencer, prompt or slow
module sys_mem_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire trap_pkg::mem_req_t mem_req,
    input wire logic slow,
    input wire logic abort_en,
    input wire logic [15:0] abort_addr,
    output trap_pkg::mem_rsp_t mem_rsp
);
    logic [15:0] mem [0:255]; // Word store for the low 512 bytes
    logic [1:0] wait_r = 2'h0; // Wait states before a slow ack
    logic ack_r = 1'b0; // One-cycle completion
    logic mm_r = 1'b0; // Abort flag, valid with ack
    logic used_r = 1'b0; // One abort per arming
    logic [15:0] rd_r = 16'h0000; // Last word read
    logic hit; // Write that is to be aborted
    assign hit = abort_en && !used_r && mem_req.wr && mem_req.addr == abort_addr;
    // Read data is stale outside the ack cycle, so show its inverse
    assign mem_rsp = {ack_r, mm_r, ack_r ? rd_r : ~rd_r};
    // ==========================================================
    // Access handling; an aborted write leaves memory untouched
    always @(posedge clk_sys) begin
        if (!rst_n || ack_r) begin
            ack_r <= 1'b0;
            mm_r <= 1'b0;
        end else if (mem_req.rd || mem_req.wr) begin
            wait_r <= wait_r + 2'h1;
            if (!slow || wait_r == 2'h3) begin
                ack_r <= 1'b1;
                wait_r <= 2'h0;
                mm_r <= hit;
                rd_r <= mem[mem_req.addr[8:1]];
                if (mem_req.wr && !hit) begin
                    mem[mem_req.addr[8:1]] <= mem_req.wdata;
                end
            end
        end
    end
    // Arming: the retried write must succeed
    always @(posedge clk_sys) begin
        if (!rst_n || !abort_en) begin
            used_r <= 1'b0;
        end else if (mm_r) begin
            used_r <= 1'b1;
        end
    end
endmodule // sys_mem_model

// File: verif/trap_bus_error_handling_tb.sv
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench for the trap sequencer
module trap_bus_error_handling_tb;
    localparam logic [15:0] TIV = 16'h0070; // Trap instruction vector
    localparam logic [15:0] IVEC = 16'h0060; // Device interrupt vector
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] cond_v = 10'h000; // Condition bits, halt first
    logic int_req = 1'b0;
    logic [2:0] int_prio = 3'h0;
    logic [15:0] pc_in = 16'h0000;
    logic [15:0] ksp_in = 16'h0000;
    logic [15:0] status_v = 16'h0000; // Live status, priority field kept at zero
    logic [4:0] fault_v = 5'h00; // valid, fetch, mode2, dest, odd
    logic [15:0] ir = 16'h0000;
    trap_pkg::mem_rsp_t mem_rsp;
    trap_pkg::mem_req_t mem_req;
    logic busy, halt, handler_go, inc_keep, inc_valid;
    logic [15:0] pc_out, status_out, ksp_out;
    trap_pkg::op_class_t op_class;
    logic slow = 1'b0;
    logic abort_en = 1'b0;
    logic [15:0] abort_addr = 16'h0000;
    logic [31:0] rs = 32'h4; // Xorshift state
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [31:0] exp_trap[$]; // Expected {pc, status} per handler entry
    logic exp_inc[$]; // Expected increment decisions
    // Opcode base and free bits, in class order
    logic [15:0] op_pat [0:14] = '{16'h0a00, 16'h1000, 16'h0d00, 16'h0006, 16'h7e00,
        16'h0dc0, 16'h7800, 16'h7000, 16'h7200, 16'h7400, 16'h7600, 16'h0d80, 16'h0d40,
        16'h8d00, 16'h8dc0};
    logic [15:0] op_msk [0:14] = '{16'h003f, 16'h0fff, 16'h003f, 16'h0000, 16'h01ff,
        16'h003f, 16'h01ff, 16'h01ff, 16'h01ff, 16'h01ff, 16'h01ff, 16'h003f, 16'h003f,
        16'h003f, 16'h003f};
    // Winner of each adjacent pair of conditions
    logic [15:0] vt [0:7] = '{trap_pkg::VEC_BUS_ERR, trap_pkg::VEC_MEM_MGT,
        trap_pkg::VEC_BUS_ERR, trap_pkg::VEC_PARITY, TIV, trap_pkg::VEC_TRACE,
        trap_pkg::VEC_BUS_ERR, trap_pkg::VEC_POWER};
    int sel [0:3] = '{0, 1, 11, 12}; // Basic, move, to-prev, from-prev

    trap_bus_error_handling dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .cond(trap_pkg::trap_cond_t'(cond_v)), .trap_instr_vec(TIV), .int_req(int_req),
        .int_prio(int_prio), .int_vec(IVEC), .pc_in(pc_in), .status_in(status_v),
        .ksp_in(ksp_in), .fault(trap_pkg::fault_ctx_t'(fault_v)), .ir(ir),
        .mem_rsp(mem_rsp), .mem_req(mem_req), .busy(busy), .halt(halt),
        .handler_go(handler_go), .pc_out(pc_out), .status_out(status_out),
        .ksp_out(ksp_out), .inc_keep(inc_keep), .inc_valid(inc_valid), .op_class(op_class));
    sys_mem_model mem_m (.clk_sys(clk_sys), .rst_n(rst_n), .mem_req(mem_req), .slow(slow),
        .abort_en(abort_en), .abort_addr(abort_addr), .mem_rsp(mem_rsp));

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [15:0] w(input logic [15:0] a);
        return mem_m.mem[a[8:1]];
    endfunction
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Bounded wait for busy (0) or handler entry (1)
    task automatic wait_hi(input int s);
        int k;
        k = 0;
        while ((s == 0 ? busy : handler_go) !== 1'b1 && k < 300) begin
            @(negedge clk_sys);
            k++;
        end
        check("handshake wait", k < 300, 1'b1);
    endtask
    // One trap; the interrupt variant nests a higher request
    task automatic run_trap(input logic [9:0] c, input logic [15:0] vl, input logic [15:0] sts,
        input bit irq);
        logic [15:0] ksp;
        rs = xs(rs);
        ksp = 16'h0184 + {10'h000, rs[5:1], 1'b0};
        ksp_in = ksp;
        pc_in = {rs[15:1], 1'b0};
        slow = rs[20];
        status_v = {rs[31:24], 3'h0, rs[28:24]};
        abort_addr = ksp - 16'h0004;
        exp_trap.push_back({w(irq ? IVEC : vl), w((irq ? IVEC : vl) + 16'h0002)});
        cond_v = c;
        wait_hi(0);
        cond_v = 10'h000;
        int_req = irq;
        int_prio = 3'h5;
        wait_hi(1);
        int_req = 1'b0;
        if (!irq) begin
            check("status push", w(ksp - 16'h0002), abort_en ? sts : status_v);
            check("pc push", w(ksp - 16'h0004), pc_in);
            check("ksp_out", ksp_out, ksp - 16'h0004);
        end
    endtask

    // ==========================================================
    // Result watcher: each pulse takes the oldest note
    always @(negedge clk_sys) begin
        if (handler_go === 1'b1) begin
            if (exp_trap.size() == 0) begin
                check("extra handler entry", 1'b1, 1'b0);
            end else begin
                check("handler pc,status", {pc_out, status_out}, exp_trap.pop_front());
            end
        end
        if (inc_valid === 1'b1) begin
            check("inc_keep", inc_keep, exp_inc.size() ? exp_inc.pop_front() : 1'bx);
        end
    end
    // Hang guard, well above the expected run
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        bit mv, mt;
        int k;
        for (int i = 0; i < 256; i++) begin
            mem_m.mem[i] = {i[7:0] + 8'h40, 8'h00};
        end
        mem_m.mem[IVEC[8:1] + 8'h01] = 16'h00e0; // Handler status masks all
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        check("idle outputs", {busy, halt, handler_go}, 3'h0);
        // Decoder: every class, random free bits
        for (int i = 0; i < 15; i++) begin
            rs = xs(rs);
            ir = op_pat[i] | (rs[31:16] & op_msk[i]);
            @(negedge clk_sys);
            check("op_class", op_class, i);
        end
        $display("Test decode done");
        // Fault decisions, random context, one idle cycle between faults
        for (int i = 0; i < 40; i++) begin
            rs = xs(rs);
            k = sel[rs[1:0]];
            mv = (k == 1);
            mt = (k == 11);
            ir = op_pat[k] | (rs[31:16] & op_msk[k]);
            @(negedge clk_sys);
            fault_v = {1'b1, rs[7:4]};
            exp_inc.push_back(!rs[7] && rs[6] && (rs[4] ? (mv || mt) : ((mv && rs[5]) || mt)));
            @(negedge clk_sys);
            fault_v = 5'h00;
        end
        $display("Test fault decision done");
        for (int i = 0; i < 8; i++) begin
            run_trap(10'h180 >> i, vt[i], 16'h0000, 1'b0);
        end
        $display("Test priority done");
        run_trap(10'h008, trap_pkg::VEC_TRACE, 16'h0000, 1'b1);
        $display("Test nesting done");
        // Interrupt taken from idle, nothing vectored pending
        int_req = 1'b1;
        int_prio = 3'h5;
        run_trap(10'h000, IVEC, 16'h0000, 1'b0);
        $display("Test idle interrupt done");
        abort_en = 1'b1;
        run_trap(10'h100, trap_pkg::VEC_MEM_MGT, w(16'h0006), 1'b0);
        abort_en = 1'b0;
        $display("Test abort done");
        cond_v = 10'h300;
        repeat (3) @(negedge clk_sys);
        check("halt taken", {halt, busy}, 2'h2);
        cond_v = 10'h000;
        repeat (3) @(negedge clk_sys);
        check("halt sticky", {halt, busy}, 2'h2);
        $display("Test halt done");
        give_verdict();
    end
endmodule // trap_bus_error_handling_tb
